// file: hdl/plc_line_codec.sv
// Purpose: PDH line-code encoder and decoder: AMI, HDB3, B3ZS, B6ZS, B8ZS, CMI.
// Assumes: One binary bit per clock; code_sel is static while traffic flows.
// Notes:   Encoder looks DEPTH bits ahead so whole zero runs are seen at once.
//
// Behaviour
// RQ1: AMI sends each one as a pulse opposite to the previous pulse.
// RQ2: AMI sends each zero as a space unless substitution replaces it.
// RQ3: Inserted B pulse alternates normally; V repeats the preceding polarity.
// RQ4: HDB3 replaces each run of four zeros by 000V or B00V.
// RQ5: HDB3/B3ZS choose pattern so pulses between V are odd; V alternates.
// RQ6: B3ZS replaces each run of three zeros by 00V or B0V.
// RQ7: B6ZS replaces each run of six zeros by 0VB0VB.
// RQ8: B8ZS replaces each run of eight zeros by 000VB0VB.
// RQ9: CMI sends a one as a full-bit level, alternating on successive ones.
// RQ10: CMI sends a zero as low then high halves, rising at mid-bit.
// RQ11: Decoder restores substituted zero runs and flags stray violations.
// RQ12: Static input selects code; reset clears polarity and pulse counter.
module plc_line_codec #(
    parameter int DEPTH = plc_pkg::PLC_DEPTH
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [2:0] code_sel,
    input wire logic tx_bit,
    output logic tx_pos,
    output logic tx_neg,
    output logic [1:0] tx_cmi,
    input wire logic rx_pos,
    input wire logic rx_neg,
    input wire logic [1:0] rx_cmi,
    output logic rx_bit,
    output logic rx_code_err
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    plc_pkg::plc_sym_t eq_q [DEPTH];
    plc_pkg::plc_sym_t sq [DEPTH];
    logic pol_q;
    logic par_q;
    logic tx_lvl_q;
    logic tx_pos_q;
    logic tx_neg_q;
    logic [1:0] tx_cmi_q;
    logic rx_lvl_q;
    logic rx_bit_q;
    logic rx_err_q;
    logic dec_bit;
    logic dec_err;
    logic run_hit;
    logic is_cmi;
    int run_len;

    // Zero-run length that the selected code substitutes; 0 for none
    function automatic int sub_len(input logic [2:0] code);
        case (code)
            plc_pkg::PLC_HDB3: sub_len = plc_pkg::PLC_RUN_HDB3;
            plc_pkg::PLC_B3ZS: sub_len = plc_pkg::PLC_RUN_B3ZS;
            plc_pkg::PLC_B6ZS: sub_len = plc_pkg::PLC_RUN_B6ZS;
            plc_pkg::PLC_B8ZS: sub_len = plc_pkg::PLC_RUN_B8ZS;
            default: sub_len = 0;
        endcase
    endfunction

    // Static mode select; unknown codes fall back to plain AMI
    assign is_cmi = (code_sel == plc_pkg::PLC_CMI); // see RQ12
    assign run_len = sub_len(code_sel);

    // ----------------------------------------------------------------
    // Encoder substitution at the queue head
    // ----------------------------------------------------------------
    // A run is replaced only when its first zero reaches the head, so
    // a longer run is cut into whole blocks from its start.
    always_comb begin
        run_hit = (run_len > 0);
        for (int i = 0; i < DEPTH; i++) begin
            sq[i] = eq_q[i];
            if (i < run_len && eq_q[i] != plc_pkg::PLC_SYM_Z) begin
                run_hit = 1'b0;
            end
        end
        if (run_hit) begin
            case (code_sel)
                plc_pkg::PLC_HDB3: begin
                    // Odd count since last V: 000V keeps it odd, else B00V
                    sq[0] = par_q ? plc_pkg::PLC_SYM_S : plc_pkg::PLC_SYM_B; // see RQ5
                    sq[1] = plc_pkg::PLC_SYM_S;
                    sq[2] = plc_pkg::PLC_SYM_S;
                    sq[3] = plc_pkg::PLC_SYM_V; // see RQ4
                end
                plc_pkg::PLC_B3ZS: begin
                    sq[0] = par_q ? plc_pkg::PLC_SYM_S : plc_pkg::PLC_SYM_B; // see RQ5
                    sq[1] = plc_pkg::PLC_SYM_S;
                    sq[2] = plc_pkg::PLC_SYM_V; // see RQ6
                end
                plc_pkg::PLC_B6ZS: begin
                    sq[0] = plc_pkg::PLC_SYM_S; // see RQ7
                    sq[1] = plc_pkg::PLC_SYM_V;
                    sq[2] = plc_pkg::PLC_SYM_B;
                    sq[3] = plc_pkg::PLC_SYM_S;
                    sq[4] = plc_pkg::PLC_SYM_V;
                    sq[5] = plc_pkg::PLC_SYM_B;
                end
                plc_pkg::PLC_B8ZS: begin
                    sq[0] = plc_pkg::PLC_SYM_S; // see RQ8
                    sq[1] = plc_pkg::PLC_SYM_S;
                    sq[2] = plc_pkg::PLC_SYM_S;
                    sq[3] = plc_pkg::PLC_SYM_V;
                    sq[4] = plc_pkg::PLC_SYM_B;
                    sq[5] = plc_pkg::PLC_SYM_S;
                    sq[6] = plc_pkg::PLC_SYM_V;
                    sq[7] = plc_pkg::PLC_SYM_B;
                end
                default: begin
                    sq[0] = eq_q[0];
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Encoder look-ahead queue
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (sys_rst) begin
                eq_q[i] <= plc_pkg::PLC_SYM_Z;
            end else if (i == DEPTH - 1) begin
                eq_q[i] <= tx_bit ? plc_pkg::PLC_SYM_M : plc_pkg::PLC_SYM_Z;
            end else begin
                eq_q[i] <= sq[i+1];
            end
        end
    end

    // ----------------------------------------------------------------
    // Pulse polarity and pulse-count parity
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pol_q <= plc_pkg::PLC_POL_RST; // see RQ12
        end else if (!is_cmi) begin
            case (sq[0])
                plc_pkg::PLC_SYM_M: pol_q <= ~pol_q; // see RQ1
                plc_pkg::PLC_SYM_B: pol_q <= ~pol_q; // see RQ3
                default: pol_q <= pol_q;
            endcase
        end
    end

    // Parity of alternating pulses sent since the last violation
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            par_q <= plc_pkg::PLC_PAR_RST; // see RQ12
        end else if (!is_cmi) begin
            case (sq[0])
                plc_pkg::PLC_SYM_M: par_q <= ~par_q;
                plc_pkg::PLC_SYM_B: par_q <= ~par_q;
                plc_pkg::PLC_SYM_V: par_q <= 1'b0; // see RQ5
                default: par_q <= par_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Bipolar line rails
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst || is_cmi) begin
            tx_pos_q <= 1'b0;
            tx_neg_q <= 1'b0;
        end else begin
            case (sq[0])
                plc_pkg::PLC_SYM_M, plc_pkg::PLC_SYM_B: begin
                    // Alternation: opposite to the previous pulse
                    tx_pos_q <= ~pol_q; // see RQ1
                    tx_neg_q <= pol_q; // see RQ3
                end
                plc_pkg::PLC_SYM_V: begin
                    // Violation repeats the previous polarity
                    tx_pos_q <= pol_q; // see RQ3
                    tx_neg_q <= ~pol_q;
                end
                default: begin
                    tx_pos_q <= 1'b0; // see RQ2
                    tx_neg_q <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // CMI transmit: bit 1 is the first half, bit 0 the second
    // ----------------------------------------------------------------
    // The clock runs at bit rate, so each bit is sent as a half-bit pair
    // for an external serialiser running at twice the rate.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_lvl_q <= plc_pkg::PLC_LVL_RST;
            tx_cmi_q <= 2'h0;
        end else if (!is_cmi) begin
            tx_cmi_q <= 2'h0;
        end else if (eq_q[0] == plc_pkg::PLC_SYM_M) begin
            tx_lvl_q <= ~tx_lvl_q;
            tx_cmi_q <= {2{~tx_lvl_q}}; // see RQ9
        end else begin
            tx_cmi_q <= plc_pkg::PLC_CMI_ZERO; // see RQ10
        end
    end

    // ----------------------------------------------------------------
    // Bipolar receive path
    // ----------------------------------------------------------------
    plc_zs_decoder #(
        .DEPTH(DEPTH)
    ) u_dec (
        .clock(clock),
        .sys_rst(sys_rst),
        .code_sel(code_sel),
        .rx_pos(rx_pos),
        .rx_neg(rx_neg),
        .dec_bit(dec_bit),
        .dec_err(dec_err)
    );

    // ----------------------------------------------------------------
    // Receive output, CMI decoded in place
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_lvl_q <= plc_pkg::PLC_LVL_RST;
            rx_bit_q <= 1'b0;
            rx_err_q <= 1'b0;
        end else if (!is_cmi) begin
            rx_bit_q <= dec_bit; // see RQ11
            rx_err_q <= dec_err;
        end else begin
            case (rx_cmi)
                2'h0, 2'h3: begin
                    // Full-bit level: a one, must differ from the last one
                    rx_bit_q <= 1'b1; // see RQ9
                    rx_err_q <= (rx_cmi[0] == rx_lvl_q);
                    rx_lvl_q <= rx_cmi[0];
                end
                plc_pkg::PLC_CMI_ZERO: begin
                    rx_bit_q <= 1'b0; // see RQ10
                    rx_err_q <= 1'b0;
                end
                default: begin
                    // Falling mid-bit transition is never legal
                    rx_bit_q <= 1'b0;
                    rx_err_q <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign tx_pos = tx_pos_q;
    assign tx_neg = tx_neg_q;
    assign tx_cmi = tx_cmi_q;
    assign rx_bit = rx_bit_q;
    assign rx_code_err = rx_err_q;

endmodule

// file: hdl/plc_pkg.sv
// Purpose: Shared constants and types for the PDH line-code encoder/decoder.
// Assumes: One bit per clock on both the framing side and the line side.
// Notes:   Code select values, run lengths and reset polarities live here.
package plc_pkg;

    // ----------------------------------------------------------------
    // Line code selection
    // ----------------------------------------------------------------
    localparam logic [2:0] PLC_AMI = 3'h0;
    localparam logic [2:0] PLC_HDB3 = 3'h1;
    localparam logic [2:0] PLC_B3ZS = 3'h2;
    localparam logic [2:0] PLC_B6ZS = 3'h3;
    localparam logic [2:0] PLC_B8ZS = 3'h4;
    localparam logic [2:0] PLC_CMI = 3'h5;

    // ----------------------------------------------------------------
    // Zero-run lengths replaced by each substitution code
    // ----------------------------------------------------------------
    localparam int PLC_RUN_HDB3 = 4;
    localparam int PLC_RUN_B3ZS = 3;
    localparam int PLC_RUN_B6ZS = 6;
    localparam int PLC_RUN_B8ZS = 8;

    // Look-ahead depth: must cover the longest run
    localparam int PLC_DEPTH = 8;

    // ----------------------------------------------------------------
    // Reset values and CMI half-bit symbols
    // ----------------------------------------------------------------
    localparam logic PLC_POL_RST = 1'b0;
    localparam logic PLC_PAR_RST = 1'b0;
    localparam logic PLC_LVL_RST = 1'b0;
    localparam logic [1:0] PLC_CMI_ZERO = 2'h1;
    localparam logic [1:0] PLC_CMI_BAD = 2'h2;

    // Symbol classes queued in the encoder
    typedef enum logic [2:0] {
        PLC_SYM_Z,
        PLC_SYM_S,
        PLC_SYM_M,
        PLC_SYM_B,
        PLC_SYM_V
    } plc_sym_t;

endpackage

// file: hdl/plc_zs_decoder.sv
// Purpose: Bipolar receive decoder for AMI and the zero-substitution codes.
// Assumes: One symbol per clock; both rails high is an illegal symbol.
// Notes:   Bits leave DEPTH cycles after entry; errors are judged on exit.
module plc_zs_decoder #(
    parameter int DEPTH = plc_pkg::PLC_DEPTH
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [2:0] code_sel,
    input wire logic rx_pos,
    input wire logic rx_neg,
    output logic dec_bit,
    output logic dec_err
);

    logic pul_q [DEPTH];
    logic vio_q [DEPTH];
    logic ers_q [DEPTH];
    logic pul_n [DEPTH];
    logic vio_n [DEPTH];
    logic ers_n [DEPTH];
    logic hit [DEPTH];
    logic last_pol_q;

    // A space, or a pulse already restored to zero
    function automatic logic is_zero(input logic p, input logic e);
        is_zero = !p || e;
    endfunction

    // Pulse that keeps alternation
    function automatic logic is_bal(input logic p, input logic v, input logic e);
        is_bal = p && !v && !e;
    endfunction

    // Pulse that breaks alternation
    function automatic logic is_vio(input logic p, input logic v, input logic e);
        is_vio = p && v && !e;
    endfunction

    // ----------------------------------------------------------------
    // Window with the new symbol shifted in
    // ----------------------------------------------------------------
    always_comb begin
        pul_n[0] = rx_pos ^ rx_neg;
        // Illegal double pulse is kept as an unmatched violation
        vio_n[0] = (rx_pos && rx_neg) || (rx_pos ^ rx_neg && rx_pos == last_pol_q);
        ers_n[0] = 1'b0;
        for (int i = 1; i < DEPTH; i++) begin
            pul_n[i] = pul_q[i-1];
            vio_n[i] = vio_q[i-1];
            ers_n[i] = ers_q[i-1];
        end
    end

    // ----------------------------------------------------------------
    // Pattern recognition, newest symbol at index 0
    // ----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            hit[i] = 1'b0;
        end
        case (code_sel)
            plc_pkg::PLC_HDB3: begin
                // 000V or B00V: restore V and the leading B
                if (is_vio(pul_n[0], vio_n[0], ers_n[0]) && is_zero(pul_n[1], ers_n[1])
                    && is_zero(pul_n[2], ers_n[2])
                    && !is_vio(pul_n[3], vio_n[3], ers_n[3])) begin // see RQ11
                    hit[0] = 1'b1;
                    hit[3] = 1'b1;
                end
            end
            plc_pkg::PLC_B3ZS: begin
                if (is_vio(pul_n[0], vio_n[0], ers_n[0]) && is_zero(pul_n[1], ers_n[1])
                    && !is_vio(pul_n[2], vio_n[2], ers_n[2])) begin // see RQ11
                    hit[0] = 1'b1;
                    hit[2] = 1'b1;
                end
            end
            plc_pkg::PLC_B6ZS: begin
                // 0VB0VB, matched when the final B arrives
                if (is_bal(pul_n[0], vio_n[0], ers_n[0]) && is_vio(pul_n[1], vio_n[1], ers_n[1])
                    && is_zero(pul_n[2], ers_n[2]) && is_bal(pul_n[3], vio_n[3], ers_n[3])
                    && is_vio(pul_n[4], vio_n[4], ers_n[4])
                    && is_zero(pul_n[5], ers_n[5])) begin // see RQ11
                    hit[0] = 1'b1;
                    hit[1] = 1'b1;
                    hit[3] = 1'b1;
                    hit[4] = 1'b1;
                end
            end
            plc_pkg::PLC_B8ZS: begin
                if (is_bal(pul_n[0], vio_n[0], ers_n[0]) && is_vio(pul_n[1], vio_n[1], ers_n[1])
                    && is_zero(pul_n[2], ers_n[2]) && is_bal(pul_n[3], vio_n[3], ers_n[3])
                    && is_vio(pul_n[4], vio_n[4], ers_n[4]) && is_zero(pul_n[5], ers_n[5])
                    && is_zero(pul_n[6], ers_n[6])
                    && is_zero(pul_n[7], ers_n[7])) begin // see RQ11
                    hit[0] = 1'b1;
                    hit[1] = 1'b1;
                    hit[3] = 1'b1;
                    hit[4] = 1'b1;
                end
            end
            default: begin
                hit[0] = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Window and received polarity
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (sys_rst) begin
                pul_q[i] <= 1'b0;
                vio_q[i] <= 1'b0;
                ers_q[i] <= 1'b0;
            end else begin
                pul_q[i] <= pul_n[i];
                vio_q[i] <= vio_n[i];
                ers_q[i] <= ers_n[i] || hit[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            last_pol_q <= plc_pkg::PLC_POL_RST; // see RQ12
        end else if (rx_pos ^ rx_neg) begin
            last_pol_q <= rx_pos;
        end
    end

    // A violation leaving unclaimed fits no valid pattern
    assign dec_bit = pul_q[DEPTH-1] && !ers_q[DEPTH-1];
    assign dec_err = vio_q[DEPTH-1] && !ers_q[DEPTH-1]; // see RQ11

endmodule

// file: verification/plc_line_codec_monitor.sv
// Purpose: Concurrent checks on the ports of the line codec.
// Assumes: Bound to plc_line_codec; one bit per clock.
// Notes: Helper registers track last pulse polarity and last CMI level.
module plc_line_codec_monitor #(
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [2:0] code_sel,
    input wire logic tx_bit,
    input wire logic tx_pos,
    input wire logic tx_neg,
    input wire logic [1:0] tx_cmi,
    input wire logic rx_pos,
    input wire logic rx_neg,
    input wire logic [1:0] rx_cmi,
    input wire logic rx_bit,
    input wire logic rx_code_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic is_ami, is_cmi, is_zs, pulse, is_v;
    logic last_pol_q, cnt_q, have_v_q, lvl_q;
    // Sampled reset is folded in: the release edge itself takes no bit
    assign is_ami = !sys_rst && code_sel == plc_pkg::PLC_AMI;
    assign is_cmi = !sys_rst && code_sel == plc_pkg::PLC_CMI;
    assign is_zs = !sys_rst && (code_sel == plc_pkg::PLC_HDB3 || code_sel == plc_pkg::PLC_B3ZS);
    assign pulse = tx_pos | tx_neg;
    assign is_v = pulse && (tx_pos == last_pol_q);
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            last_pol_q <= 1'b0;
        end else if (pulse) begin
            last_pol_q <= tx_pos;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_q <= 1'b0;
            have_v_q <= 1'b0;
        end else if (is_v) begin
            cnt_q <= 1'b0;
            have_v_q <= 1'b1;
        end else if (pulse) begin
            cnt_q <= ~cnt_q;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lvl_q <= 1'b0;
        end else if (is_cmi && tx_cmi[1] == tx_cmi[0]) begin
            lvl_q <= tx_cmi[1];
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // ------
    // Assertions
    // ------
    AST_RAIL_EXCL: assert property (!(tx_pos && tx_neg))
        else $error("both rails driven at once");
    AST_AMI_ONE: assert property (is_ami && tx_bit |-> ##9 pulse)
        else $error("one not sent as a pulse");
    AST_AMI_ZERO: assert property (is_ami && !tx_bit |-> ##9 !pulse)
        else $error("zero not sent as a space");
    AST_AMI_ALT: assert property (is_ami && pulse |-> tx_pos != last_pol_q)
        else $error("mark did not alternate");
    AST_V_ODD: assert property (is_zs && is_v && have_v_q |-> cnt_q)
        else $error("even pulse count between violations");
    AST_CMI_ZERO: assert property (is_cmi && !tx_bit |-> ##9 tx_cmi == plc_pkg::PLC_CMI_ZERO)
        else $error("zero not sent low then high");
    AST_CMI_ONE: assert property (is_cmi && tx_bit |-> ##9 tx_cmi == {2{~lvl_q}})
        else $error("one level did not alternate");
    AST_CMI_RX_BAD: assert property (is_cmi && rx_cmi == plc_pkg::PLC_CMI_BAD |=> rx_code_err)
        else $error("falling mid-bit symbol not flagged");
    AST_RST_CLEAR: assert property ($fell(sys_rst) |-> !pulse && !rx_bit && !rx_code_err)
        else $error("outputs not cleared by reset");
    COV_AMI_MARK: cover property (is_ami && tx_neg);
    COV_ZS_VIOL: cover property (is_zs && is_v && have_v_q);
    COV_CMI_BAD: cover property (is_cmi && rx_code_err);
endmodule

// file: verification/plc_line_codec_test.sv
// Purpose: Self-checking bench for the line codec over a loop-back line.
// Assumes: One fixed pattern holding runs of 3 to 9 zeros, sent per code.
// Notes: Eight reset zeros precede each stream and shape the coder state.
module plc_line_codec_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [0:47] PAT = 48'h861104080401;
    logic clock, tx_pos, tx_neg, rx_pos, rx_neg, rx_bit, rx_code_err;
    logic sys_rst = 1'b1;
    logic tx_bit = 1'b1;
    logic flip = 1'b0;
    logic [2:0] code_sel = 3'h0;
    logic [1:0] tx_cmi, rx_cmi;
    logic [1:0] rec_rail [0:71];
    logic [1:0] rec_cmi [0:71];
    logic [1:0] rec_rx [0:71];
    logic [1:0] exp_rail [0:55];
    logic [1:0] exp_cmi [0:55];
    int n_fail = 0;
    int check_count = 0;
    plc_line_codec #(.DEPTH(8)) dut (.clock(clock), .sys_rst(sys_rst), .code_sel(code_sel),
        .tx_bit(tx_bit), .tx_pos(tx_pos), .tx_neg(tx_neg), .tx_cmi(tx_cmi), .rx_pos(rx_pos),
        .rx_neg(rx_neg), .rx_cmi(rx_cmi), .rx_bit(rx_bit), .rx_code_err(rx_code_err));
    plc_line_model u_line (.flip(flip), .tx_pos(tx_pos), .tx_neg(tx_neg), .tx_cmi(tx_cmi),
        .rx_pos(rx_pos), .rx_neg(rx_neg), .rx_cmi(rx_cmi));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic check(input logic [1:0] seen, input logic [1:0] want);
        check_count++;
        if (seen !== want) begin
            n_fail++;
            $display("[FAIL] %0t ns: got %h, want %h", $time, seen, want);
        end
    endtask
    task automatic stop_test();
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    function automatic string subst(input logic [2:0] code, input logic odd);
        case (code)
            plc_pkg::PLC_HDB3: return odd ? "000V" : "B00V";
            plc_pkg::PLC_B3ZS: return odd ? "00V" : "B0V";
            plc_pkg::PLC_B6ZS: return "0VB0VB";
            plc_pkg::PLC_B8ZS: return "000VB0VB";
            default: return "";
        endcase
    endfunction
    // ------
    // Behavioural encoder: runs cut into whole blocks from their first zero
    // ------
    task automatic ref_encode(input logic [2:0] code);
        logic [0:55] full;
        logic pol, odd, lvl;
        int i, j, k, run;
        string p;
        full = {8'h00, PAT};
        pol = 1'b0;
        odd = 1'b0;
        lvl = 1'b0;
        i = 0;
        while (i < 56) begin
            if (full[i]) begin
                pol = ~pol;
                odd = ~odd;
                lvl = ~lvl;
                exp_rail[i] = pol ? 2'h2 : 2'h1;
                exp_cmi[i] = {lvl, lvl};
                i++;
            end else begin
                run = 0;
                while (i + run < 56 && !full[i + run]) begin
                    exp_rail[i + run] = 2'h0;
                    exp_cmi[i + run] = plc_pkg::PLC_CMI_ZERO;
                    run++;
                end
                j = 0;
                p = subst(code, odd);
                while (p.len() > 0 && j + p.len() <= run) begin
                    for (k = 0; k < p.len(); k++) begin
                        if (p[k] == "B") begin
                            pol = ~pol;
                            odd = ~odd;
                        end
                        if (p[k] == "V") begin
                            odd = 1'b0;
                        end
                        if (p[k] != "0") begin
                            exp_rail[i + j + k] = pol ? 2'h2 : 2'h1;
                        end
                    end
                    j += p.len();
                    p = subst(code, odd);
                end
                i += run;
            end
        end
    endtask
    task automatic run_stream(input logic [2:0] code, input int flip_at);
        sys_rst <= 1'b1;
        code_sel <= code;
        tx_bit <= 1'b1;
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        for (int c = 0; c < 72; c++) begin
            tx_bit <= (c < 48) ? PAT[c] : 1'b1;
            flip <= (c == flip_at);
            @(negedge clock);
            rec_rail[c] = {tx_pos, tx_neg};
            rec_cmi[c] = tx_cmi;
            rec_rx[c] = {rx_bit, rx_code_err};
            @(posedge clock);
        end
    endtask
    // Bit i is taken at slot i+1 and its line symbol stands at slot i+9;
    // it comes back decoded at i+18, or at i+10 in CMI
    task automatic verify(input logic [2:0] code, input int bad_a, input int bad_b);
        int lat;
        ref_encode(code);
        lat = (code == plc_pkg::PLC_CMI) ? 10 : 18;
        for (int i = 0; i < 48; i++) begin
            if (code == plc_pkg::PLC_CMI) begin
                check(rec_cmi[i + 9], exp_cmi[i + 8]);
            end else begin
                check(rec_rail[i + 9], exp_rail[i + 8]);
            end
            check(rec_rx[i + lat], {PAT[i], 1'(i == bad_a || i == bad_b)});
        end
    endtask
    task automatic test_ami();
        run_stream(plc_pkg::PLC_AMI, -1);
        verify(plc_pkg::PLC_AMI, -1, -1);
    endtask
    task automatic test_odd_pulse_codes();
        run_stream(plc_pkg::PLC_HDB3, -1);
        verify(plc_pkg::PLC_HDB3, -1, -1);
        run_stream(plc_pkg::PLC_B3ZS, -1);
        verify(plc_pkg::PLC_B3ZS, -1, -1);
    endtask
    task automatic test_fixed_codes();
        run_stream(plc_pkg::PLC_B6ZS, -1);
        verify(plc_pkg::PLC_B6ZS, -1, -1);
        run_stream(plc_pkg::PLC_B8ZS, -1);
        verify(plc_pkg::PLC_B8ZS, -1, -1);
    endtask
    task automatic test_cmi();
        run_stream(plc_pkg::PLC_CMI, -1);
        verify(plc_pkg::PLC_CMI, -1, -1);
    endtask
    // Swapping mark 5 makes both it and mark 6 repeat the previous polarity
    // The line symbol of bit i is corrupted by flipping at slot i+9
    task automatic test_line_faults();
        run_stream(plc_pkg::PLC_AMI, 14);
        verify(plc_pkg::PLC_AMI, 5, 6);
        run_stream(plc_pkg::PLC_CMI, 10);
        verify(plc_pkg::PLC_CMI, 1, -1);
    endtask
    initial begin
        test_ami();
        test_odd_pulse_codes();
        test_fixed_codes();
        test_cmi();
        test_line_faults();
        stop_test();
    end
endmodule
bind plc_line_codec plc_line_codec_monitor #(.DEPTH(DEPTH)) u_mon (.clock(clock),
    .sys_rst(sys_rst), .code_sel(code_sel), .tx_bit(tx_bit), .tx_pos(tx_pos),
    .tx_neg(tx_neg), .tx_cmi(tx_cmi), .rx_pos(rx_pos), .rx_neg(rx_neg), .rx_cmi(rx_cmi),
    .rx_bit(rx_bit), .rx_code_err(rx_code_err));

// file: verification/plc_line_model.sv
// Purpose: Transmission line from the codec output back to its input.
// Assumes: Zero delay loop-back of the local transmitter.
// Notes: flip corrupts exactly one symbol, only when a scenario asks.
module plc_line_model (
    input wire logic flip,
    input wire logic tx_pos,
    input wire logic tx_neg,
    input wire logic [1:0] tx_cmi,
    output logic rx_pos,
    output logic rx_neg,
    output logic [1:0] rx_cmi
);
    timeunit 1ns;
    timeprecision 1ps;
    // A swapped pulse repeats the previous polarity: a stray violation
    assign rx_pos = flip ? tx_neg : tx_pos;
    assign rx_neg = flip ? tx_pos : tx_neg;
    assign rx_cmi = flip ? ~tx_cmi : tx_cmi;
endmodule
